/* File: logic/trig_latch_pkg.sv */
// Purpose: constants for the externally clocked sequential trigger latch
// Assumes: 32-bit classic wishbone, word aligned registers
// Notes:   product config is one byte per product term
package trig_latch_pkg;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  localparam int          NUM_CHAN      = 4;
  localparam logic [7:0]  OFF_PRODUCTS  = 8'h00;
  localparam logic [7:0]  OFF_CONTROL   = 8'h04;
  localparam logic [7:0]  OFF_STATUS    = 8'h08;
  // product byte fields
  localparam int          POS_CH_EN     = 0;
  localparam int          POS_CH_INV    = 4;
  localparam int          POS_EDGE_SEL  = 0;
  // control fields
  localparam int          POS_SYNC      = 0;
  localparam int          POS_SLOPE     = 1;
  localparam int          POS_EXER      = 2;
  localparam int          POS_TRIG_EN   = 3;
  localparam int          POS_EDGE_EN   = 4;
  localparam int          POS_EDGE_CH   = 8;
  localparam int          POS_EDGE_NEG  = 16;
  // status fields
  localparam int          POS_LATCH     = 0;
  localparam int          POS_CLKMON    = 1;
  localparam logic [31:0] RST_PRODUCTS  = 32'h00000000;
  localparam logic [31:0] RST_CONTROL   = 32'h00000000;
endpackage

/* File: logic/trig_latch.sv */
// Purpose: sequential trigger latch with external clock qualification
// Assumes: ext_clk_i unrelated to clk_i; chan_i asynchronous levels
// Notes:   latch lives in clk_i domain; external clock edges cross by
//          two flops and are edge detected after the second flop
`timescale 1ns/100ps
// Functional notes
// RL1: sync control high makes the latch change only on external clock events
// RL2: exercise pulse with a true set product sets latch; status reads high
// RL3: exercise pulse with first reset product true clears latch; status low
// RL4: second set and reset products behave the same as the first pair
// RL5: each product term takes each channel true or complemented
// RL6: exercise 1, sync 0, slope 1 gives clock monitor bit 0
// RL7: exercise 1, sync 0, slope 0 gives clock monitor bit 1
// RL8: exercise 1, sync 1, slope 0 gives clock monitor bit 0
// RL9: each product may be qualified by a rising or falling channel edge
// RL10: latch stays set when function a falls; clears only on reset event
// RL11: trigger enable low resets latch regardless of function a
// RL12: processor loads setup before strobing and reads status afterwards
module trig_latch (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ext_clk_i,
  input  wire logic [trig_latch_pkg::NUM_CHAN-1:0] chan_i,
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [trig_latch_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]                          sel_i,
  input  wire logic [trig_latch_pkg::DATA_W-1:0]   dat_i,
  output logic      [trig_latch_pkg::DATA_W-1:0]   dat_o,
  output logic                                     ack_o,
  output logic                                     latch_status_bit_o,
  output logic                                     clock_monitor_bit_o
);
  import trig_latch_pkg::*;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_type;

  // link domain: external clock divided to a toggle per rising edge
  logic        ext_toggle_reg;
  logic        ext_toggle_next;
  // ext_clk_i runs as the clock; the toggle holds its last value when idle
  always_comb begin
    ext_toggle_next = ~ext_toggle_reg;
  end
  // rst_i clears it directly: the pin clock may be stopped during reset,
  // and an unknown toggle would hide every later pin edge
  always_ff @(posedge ext_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_toggle_reg <= 1'b0;
    end else begin
      ext_toggle_reg <= ext_toggle_next;
    end
  end

  // sync stages
  logic [2:0]          tog_sync_reg;
  logic [2:0]          tog_sync_next;
  logic [NUM_CHAN-1:0] ch_s1_reg;
  logic [NUM_CHAN-1:0] ch_s2_reg;
  logic [NUM_CHAN-1:0] ch_s3_reg;
  logic [NUM_CHAN-1:0] ch_s1_next;
  logic [NUM_CHAN-1:0] ch_s2_next;
  logic [NUM_CHAN-1:0] ch_s3_next;
  logic                lvl_s1_reg;
  logic                lvl_s2_reg;
  logic                lvl_s1_next;
  logic                lvl_s2_next;

  always_comb begin
    tog_sync_next = {tog_sync_reg[1:0], ext_toggle_reg};
    ch_s1_next    = chan_i;
    ch_s2_next    = ch_s1_reg;
    ch_s3_next    = ch_s2_reg;
    lvl_s1_next   = ext_clk_i;
    lvl_s2_next   = lvl_s1_reg;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_sync_reg <= 3'h0;
      ch_s1_reg    <= '0;
      ch_s2_reg    <= '0;
      ch_s3_reg    <= '0;
      lvl_s1_reg   <= 1'b0;
      lvl_s2_reg   <= 1'b0;
    end else begin
      tog_sync_reg <= tog_sync_next;
      ch_s1_reg    <= ch_s1_next;
      ch_s2_reg    <= ch_s2_next;
      ch_s3_reg    <= ch_s3_next;
      lvl_s1_reg   <= lvl_s1_next;
      lvl_s2_reg   <= lvl_s2_next;
    end
  end

  // registers
  logic [31:0]   products_reg;
  logic [31:0]   products_next;
  logic [31:0]   control_reg;
  logic [31:0]   control_next;
  logic [31:0]   dat_reg;
  logic [31:0]   dat_next;
  bus_state_type bus_reg;
  bus_state_type bus_next;
  logic          exer_prev_reg;
  logic          exer_prev_next;
  logic          latch_reg;
  logic          latch_next;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // one product byte: enable and invert per channel; edge qualifier is applied later from control
  function automatic logic prod_level(input logic [7:0]          cfg,
                                      input logic [NUM_CHAN-1:0] ch);
    logic r;
    r = |cfg[POS_CH_EN +: NUM_CHAN];
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (cfg[POS_CH_EN + i]) begin
        r = r & (ch[i] ^ cfg[POS_CH_INV + i]); // RL5
      end
    end
    return r;
  endfunction

  wire        sync_en   = control_reg[POS_SYNC];
  wire        slope_sel = control_reg[POS_SLOPE];
  wire        exer_bit  = control_reg[POS_EXER];
  wire        trig_en   = control_reg[POS_TRIG_EN];
  wire [3:0]  edge_en   = control_reg[POS_EDGE_EN +: 4];

  // per product: level term and optional edge strobe
  logic [3:0] prod_lvl;
  logic [3:0] prod_strobe;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_prod
      logic [1:0] ech;
      logic       eneg;
      logic       rise;
      logic       fall;
      assign ech  = control_reg[POS_EDGE_CH + 2*g +: 2];
      assign eneg = control_reg[POS_EDGE_NEG + g];
      assign rise = ch_s2_reg[ech] & ~ch_s3_reg[ech];
      assign fall = ~ch_s2_reg[ech] & ch_s3_reg[ech];
      assign prod_lvl[g] = prod_level(products_reg[8*g +: 8], ch_s2_reg);
      // edge qualification turns the product into a one-cycle strobe
      assign prod_strobe[g] = prod_lvl[g] &
                              (~edge_en[g] | (eneg ? fall : rise)); // RL9
    end
  endgenerate

  wire set_product_first    = prod_strobe[0];
  wire set_product_second   = prod_strobe[1];
  wire reset_product_first  = prod_strobe[2];
  wire reset_product_second = prod_strobe[3];
  wire function_a_result    = set_product_first | set_product_second;
  wire function_b_result    = reset_product_first | reset_product_second;

  // buffered clock: exercise control bit level or the synced pin, polarity by slope
  wire ext_edge_event  = tog_sync_reg[2] ^ tog_sync_reg[1];
  wire exer_pulse      = exer_bit & ~exer_prev_reg;
  wire ext_clock_event = ext_edge_event | exer_pulse;
  wire buffered_ext_clock = (exer_bit | lvl_s2_reg) ^ slope_sel;

  wire bus_req = cyc_i & stb_i & (bus_reg == BUS_IDLE);
  wire bus_wr  = bus_req & we_i;

  always_comb begin
    products_next  = products_reg;
    control_next   = control_reg;
    dat_next       = dat_reg;
    bus_next       = BUS_IDLE;
    exer_prev_next = exer_bit;
    latch_next     = latch_reg;
    case (bus_reg)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_next = BUS_ACK;
          case (adr_i)
            OFF_PRODUCTS: dat_next = products_reg;
            OFF_CONTROL:  dat_next = control_reg;
            OFF_STATUS:   dat_next = {30'h0, clock_monitor_bit_o,
                                      latch_status_bit_o};
            default:      dat_next = 32'h0;
          endcase
          if (bus_wr && adr_i == OFF_PRODUCTS) begin
            products_next = merge(products_reg, dat_i, sel_i);
          end
          if (bus_wr && adr_i == OFF_CONTROL) begin
            control_next = merge(control_reg, dat_i, sel_i);
          end
        end
      end
      BUS_ACK:  bus_next = BUS_IDLE;
      default:  bus_next = BUS_IDLE;
    endcase
    // latch: set term first, then reset term, trigger enable overrides all
    if (!sync_en || ext_clock_event) begin // RL1
      if (function_a_result) begin
        latch_next = 1'b1; // RL2 RL4
      end else if (function_b_result) begin
        latch_next = 1'b0; // RL3 RL4
      end
    end
    // no branch clears on function a falling
    if (!trig_en) begin
      latch_next = 1'b0; // RL11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      products_reg  <= RST_PRODUCTS;
      control_reg   <= RST_CONTROL;
      dat_reg       <= 32'h0;
      bus_reg       <= BUS_IDLE;
      exer_prev_reg <= 1'b0;
      latch_reg     <= 1'b0;
    end else begin
      products_reg  <= products_next;
      control_reg   <= control_next;
      dat_reg       <= dat_next;
      bus_reg       <= bus_next;
      exer_prev_reg <= exer_prev_next;
      latch_reg     <= latch_next; // RL10
    end
  end

  // monitor gated off while sync is on: clock consumed by the latch path
  logic monitor_reg;
  logic monitor_next;
  always_comb begin
    monitor_next = buffered_ext_clock & ~sync_en; // RL6 RL7 RL8
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      monitor_reg <= 1'b0;
    end else begin
      monitor_reg <= monitor_next;
    end
  end

  assign dat_o               = dat_reg;
  assign ack_o               = (bus_reg == BUS_ACK);
  assign latch_status_bit_o  = latch_reg;
  assign clock_monitor_bit_o = monitor_reg;

  a_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (sync_en && !ext_clock_event && trig_en) |=> $stable(latch_reg))
    else $error("latch moved without external clock event"); // RL1
  a_set_exer: assert property (@(posedge clk_i) disable iff (rst_i)
    (exer_pulse && function_a_result && trig_en) |=> latch_reg)
    else $error("exercise with set product did not set latch"); // RL2
  a_reset_exer: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_clock_event && reset_product_first && !function_a_result)
      |=> !latch_reg)
    else $error("exercise with reset product did not clear"); // RL3
  a_second_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_clock_event && reset_product_second && !function_a_result)
      |=> !latch_reg)
    else $error("second reset product did not clear"); // RL4
  a_mon_slope1: assert property (@(posedge clk_i) disable iff (rst_i)
    (exer_bit && !sync_en && slope_sel) [*2] |=> !monitor_reg)
    else $error("monitor bit not 0 with slope 1"); // RL6
  a_mon_slope0: assert property (@(posedge clk_i) disable iff (rst_i)
    (exer_bit && !sync_en && !slope_sel) |=> monitor_reg)
    else $error("monitor bit not 1 with slope 0"); // RL7
  a_mon_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    (exer_bit && sync_en && !slope_sel) |=> !monitor_reg)
    else $error("monitor bit not 0 with sync on"); // RL8
  a_stay_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (latch_reg && trig_en && !function_b_result) |=> latch_reg)
    else $error("latch cleared without reset event"); // RL10
  a_trig_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !trig_en |=> !latch_reg)
    else $error("trigger enable low did not clear latch"); // RL11
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_edge_qual: assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_en[0] && (ch_s2_reg == ch_s3_reg)) |-> !prod_strobe[0])
    else $error("edge qualified product fired without an edge"); // RL9
  a_exer_single: assert property (@(posedge clk_i) disable iff (rst_i)
    exer_pulse |=> !exer_pulse)
    else $error("exercise pulse longer than one cycle"); // RL2
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !we_i && adr_i == OFF_STATUS)
      |=> (dat_o[POS_LATCH] == $past(latch_reg)))
    else $error("status read did not return latch state"); // RL2
  a_mon_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (!exer_bit && !sync_en && !slope_sel)
      |=> (monitor_reg == $past(lvl_s2_reg)))
    else $error("monitor bit does not follow the clock pin"); // RL7
endmodule

/* File: bench/ext_clock_source.sv */
// Purpose: external clock source feeding the trigger latch pin
// Assumes: the bench opens and closes frames with run_i
// Notes:   pin stands low between frames so no stray edge is seen
`timescale 1ns/100ps
module ext_clock_source (
  input  wire logic run_i,
  output logic      ext_clk_o
);
  // odd start offset keeps this clock unrelated in phase to clk_i
  initial begin
    ext_clk_o = 1'b0;
    #7.3;
    forever begin
      if (run_i) begin
        #16 ext_clk_o = ~ext_clk_o;
      end else begin
        ext_clk_o = 1'b0;
        #16;
      end
    end
  end
endmodule

/* File: bench/sequential_trigger_latch_extclk_tb_top.sv */
// Purpose: self-checking bench for the external clock trigger latch
// Assumes: latch and monitor settle within six system cycles
// Notes:   expected latch state in the random test comes from an integer product model
`timescale 1ns/100ps
module sequential_trigger_latch_extclk_tb_top;
  import trig_latch_pkg::*;
  logic        clk_i, rst_i, ext_clk_i, req, we, ack, lat, mon, run;
  logic [3:0]  chan;
  logic [7:0]  adr, pa, pb;
  logic [31:0] dat, dat_o, rdata;
  int          miscompares, cmp_count, seed, el, i;

  trig_latch dut (.clk_i, .rst_i, .ext_clk_i, .chan_i(chan), .cyc_i(req),
    .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .latch_status_bit_o(lat),
    .clock_monitor_bit_o(mon));
  ext_clock_source far (.run_i(run), .ext_clk_o(ext_clk_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      miscompares++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdata = dat_o;
    req <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic lat_is(input logic e);
    repeat (6) @(posedge clk_i);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rdata[POS_LATCH], e);
    chk(lat, e);
  endtask
  function automatic logic [31:0] ctl(input int sy, sl, ex, te, hi);
    return 32'(hi | sy << POS_SYNC | sl << POS_SLOPE | ex << POS_EXER
               | te << POS_TRIG_EN);
  endfunction
  // setup is written with the strobe low, so only the rise pulses
  task automatic strobe(input logic [31:0] c);
    wb(1'b1, OFF_CONTROL, c);
    wb(1'b1, OFF_CONTROL, c | ctl(0, 0, 1, 0, 0));
  endtask
  function automatic bit pt(input logic [7:0] p, input logic [3:0] c);
    return p[3:0] != 4'h0 && ((c ^ p[7:4]) | ~p[3:0]) == 4'hf;
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    seed = 32'ha111b538;
    rst_i <= 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    chan = 4'h0;
    run = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    lat_is(1'b0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rdata[POS_LATCH], 1'b0);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      wb(1'b1, OFF_PRODUCTS, (32'h01 << 8*i) | (32'h11 << 8*(i+2)));
      chan <= 4'h1;
      wb(1'b1, OFF_CONTROL, ctl(1, 0, 0, 1, 0));
      lat_is(1'b0);
      strobe(ctl(1, 0, 0, 1, 0));
      lat_is(1'b1);
      chan <= 4'h0;
      lat_is(1'b1);
      strobe(ctl(1, 0, 0, 1, 0));
      lat_is(1'b0);
    end
    chan <= 4'h1;
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    run <= 1'b0;
    lat_is(1'b1);
    $display("test exercise and pin done");
    for (i = 0; i < 3; i++) begin
      wb(1'b1, OFF_CONTROL, ctl(i == 2, i == 0, 1, 0, 0));
      repeat (6) @(posedge clk_i);
      wb(1'b0, OFF_STATUS, 32'h0);
      chk(rdata[POS_CLKMON], i == 1);
      chk(mon, i == 1);
    end
    $display("test monitor done");
    chan <= 4'h0;
    wb(1'b1, OFF_PRODUCTS, 32'h00110001);
    wb(1'b1, OFF_CONTROL, ctl(0, 0, 0, 1, 1 << POS_EDGE_EN
      | 1 << (POS_EDGE_EN+2) | 3 << POS_EDGE_CH | 3 << (POS_EDGE_CH+4)
      | 1 << (POS_EDGE_NEG+2)));
    chan <= 4'h1;
    lat_is(1'b0);
    chan <= 4'h9;
    lat_is(1'b1);
    chan <= 4'h8;
    lat_is(1'b1);
    chan <= 4'h0;
    lat_is(1'b0);
    wb(1'b1, OFF_CONTROL, ctl(0, 0, 0, 1, 0));
    wb(1'b1, OFF_PRODUCTS, 32'h01);
    chan <= 4'h1;
    lat_is(1'b1);
    chan <= 4'h0;
    lat_is(1'b1);
    wb(1'b1, OFF_CONTROL, ctl(0, 0, 0, 0, 0));
    lat_is(1'b0);
    $display("test edge and hold done");
    wb(1'b1, OFF_CONTROL, ctl(0, 0, 0, 1, 0));
    el = 0;
    for (i = 0; i < 24; i++) begin
      pa = 8'($random(seed));
      pb = 8'($random(seed));
      wb(1'b1, OFF_PRODUCTS, {8'h00, pb, 8'h00, pa});
      wb(1'b0, OFF_PRODUCTS, 32'h0);
      chk(rdata, {8'h00, pb, 8'h00, pa});
      el = pt(pa, chan) ? 1 : (pt(pb, chan) ? 0 : el);
      lat_is(el[0]);
      chan <= 4'($random(seed));
      @(posedge clk_i);
      el = pt(pa, chan) ? 1 : (pt(pb, chan) ? 0 : el);
      lat_is(el[0]);
    end
    $display("test random products done");
    close_out();
  end
endmodule
